// *** rtl/cum_mon_store.sv ***
`timescale 1ns/100ps
`include "cum_params.svh"

// -----------------------------------------------------------------
// Counter and capture words for every space, resource and monitor
// -----------------------------------------------------------------
module cum_mon_store (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  sw_cnt_we,
   input  wire logic                  sw_cap_we,
   input  wire logic [`CUM_IDX_W-1:0] sw_idx,
   input  wire logic [31:0]           sw_wdata,
   input  wire logic                  hw_meas_we,
   input  wire logic [`CUM_IDX_W-1:0] hw_meas_idx,
   input  wire logic [31:0]           hw_meas_word,
   input  wire logic                  hw_cap_we,
   input  wire logic [`CUM_IDX_W-1:0] hw_cap_idx,
   input  wire logic [`CUM_IDX_W-1:0] rd_idx,
   output logic      [31:0]           rd_cnt,
   output logic      [31:0]           rd_cap
);
   logic [31:0] cnt_q [`CUM_DEPTH];
   logic [31:0] cap_q [`CUM_DEPTH];

   // Read ports are combinational; the top registers the answer.
   always_comb begin
      rd_cnt = cnt_q[rd_idx];
      rd_cap = cap_q[rd_idx];
   end

   // Hardware measurement wins over a software write to the same
   // entry, so a live update is never lost. Counts reset not ready.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < `CUM_DEPTH; i++) begin
            cnt_q[i] <= `CUM_CNT_RST;
            cap_q[i] <= `CUM_CNT_RST;
         end
      end else begin
         if (sw_cnt_we) begin
            cnt_q[sw_idx] <= sw_wdata;
         end
         if (hw_meas_we) begin
            cnt_q[hw_meas_idx] <= hw_meas_word;
         end
         if (sw_cap_we) begin
            cap_q[sw_idx] <= sw_wdata;
         end
         if (hw_cap_we) begin
            cap_q[hw_cap_idx] <= cnt_q[hw_cap_idx];
         end
      end
   end
endmodule : cum_mon_store

// *** rtl/cum_params.svh ***
`ifndef CUM_PARAMS_SVH
`define CUM_PARAMS_SVH
// Contract
// - Resource select field only with both options
// - Sixteen-bit monitor index in selector
// - Accesses steered by index and space
// - Four separate selectors, one per space
// - Selector at 0x0800, read and write
// - Root and realm banks need extension
// - Counter reaches monitor within chosen resource
// - Without resource select, index alone chooses
// - Top counter bit flags not ready
// - Low 31 bits hold occupied bytes
// - Counter register is 32 bits wide
// - Four separate counters, one per space
// - Counter at 0x0840, read-only option honoured
// - Absent features read zero, ignore writes
// - Capture register exposes captured selected value
// - Capture follows resource and monitor index
// - Index out of range signals error

// -----------------------------------------------------------------
// Register offsets within a feature page frame
// -----------------------------------------------------------------
`define CUM_SEL_OFF   12'h800
`define CUM_CNT_OFF   12'h840
`define CUM_CAP_OFF   12'h848

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define CUM_RIS_HI    27
`define CUM_RIS_LO    24
`define CUM_MON_HI    15
`define CUM_MON_LO    0
`define CUM_NOT_READY_FLAG_BIT  31
`define CUM_SEL_RST   20'h00000
`define CUM_CNT_RST   32'h80000000

// -----------------------------------------------------------------
// Monitor store geometry
// -----------------------------------------------------------------
`define CUM_NUM_RIS   16'h0004
`define CUM_NUM_MON   16'h0008
`define CUM_IDX_W     7
`define CUM_DEPTH     128
`endif

// *** rtl/cum_pkg.sv ***
package cum_pkg;

   // Security space of an access.
   typedef enum logic [1:0] {
      CUM_SP_SEC  = 2'b00,
      CUM_SP_NS   = 2'b01,
      CUM_SP_ROOT = 2'b10,
      CUM_SP_RL   = 2'b11
   } cum_space_t;

   // Memory-mapped request into a feature page.
   typedef struct packed {
      logic        valid;
      logic        write;
      cum_space_t  space;
      logic [11:0] addr;
      logic [31:0] wdata;
   } cum_req_t;

   // Registered answer.
   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } cum_rsp_t;

   // Implementation options, static straps.
   typedef struct packed {
      logic mon_present;
      logic usage_present;
      logic capture_present;
      logic ext_id_present;
      logic ris_present;
      logic usage_ro;
      logic realm_present;
   } cum_opt_t;

   // Selector contents.
   typedef struct packed {
      logic [3:0]  resource_instance_select;
      logic [15:0] mon;
   } cum_sel_t;

   // Measurement update or capture event from the cache.
   typedef struct packed {
      logic        valid;
      cum_space_t  space;
      logic [3:0]  resource_instance_select;
      logic [15:0] mon;
      logic        not_ready_flag;
      logic [30:0] value;
   } cum_meas_t;

endpackage : cum_pkg

// *** rtl/cum_sel_bank.sv ***
`timescale 1ns/100ps
`include "cum_params.svh"

// -----------------------------------------------------------------
// One space's selector register
// -----------------------------------------------------------------
module cum_sel_bank (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              we,
   input  wire logic              ris_ok,
   input  wire logic [31:0]       wdata,
   output cum_pkg::cum_sel_t      sel_q
);
   import cum_pkg::*;

   cum_sel_t sel_d;

   // Resource field only latches when selection exists, else zero.
   always_comb begin
      sel_d = sel_q;
      if (we) begin
         sel_d.mon = wdata[`CUM_MON_HI:`CUM_MON_LO];
         sel_d.resource_instance_select = ris_ok ? wdata[`CUM_RIS_HI:`CUM_RIS_LO]
                            : 4'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sel_q <= `CUM_SEL_RST;
      end else begin
         sel_q <= sel_d;
      end
   end
endmodule : cum_sel_bank

// *** rtl/cum_top.sv ***
`timescale 1ns/100ps
`include "cum_params.svh"

// -----------------------------------------------------------------
// Usage monitor selector and counter register bank
// -----------------------------------------------------------------
module cum_top (
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  cum_pkg::cum_req_t  req,
   input  cum_pkg::cum_opt_t  opt,
   input  cum_pkg::cum_meas_t meas,
   input  cum_pkg::cum_meas_t cap_evt,
   output cum_pkg::cum_rsp_t  rsp_q
);
   import cum_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   cum_sel_t               sel_q [4];
   logic [3:0]             sel_we;
   cum_sel_t               cur;
   logic                   ris_ok;
   logic                   space_ok;
   logic                   cnt_present;
   logic                   cap_present;
   logic                   hit_sel;
   logic                   hit_cnt;
   logic                   hit_cap;
   logic [3:0]             ris_eff;
   logic                   oob;
   logic [`CUM_IDX_W-1:0]  idx;
   logic                   cnt_we;
   logic                   cap_we;
   logic                   meas_ok;
   logic [`CUM_IDX_W-1:0]  meas_idx;
   logic                   cevt_ok;
   logic [`CUM_IDX_W-1:0]  cevt_idx;
   logic [31:0]            rd_cnt;
   logic [31:0]            rd_cap;
   logic [31:0]            sel_word;
   cum_rsp_t               rsp_d;

   // -----------------------------------------------------------------
   // Option decode
   // -----------------------------------------------------------------
   // Root and realm frames behave as reserved without the extension.
   always_comb begin
      ris_ok      = opt.ext_id_present & opt.ris_present;
      space_ok    = !req.space[1] | opt.realm_present;
      cnt_present = opt.mon_present & opt.usage_present;
      cap_present = cnt_present & opt.capture_present;
   end

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   always_comb begin
      hit_sel = req.valid & space_ok & (req.addr == `CUM_SEL_OFF);
      hit_cnt = req.valid & space_ok & cnt_present
              & (req.addr == `CUM_CNT_OFF);
      hit_cap = req.valid & space_ok & cap_present
              & (req.addr == `CUM_CAP_OFF);
   end

   // -----------------------------------------------------------------
   // Per-space selectors
   // -----------------------------------------------------------------
   // Each frame writes only its own bank, so spaces never leak.
   always_comb begin
      sel_we = 4'h0;
      if (hit_sel && req.write) begin
         sel_we[req.space] = 1'b1;
      end
   end

   for (genvar s = 0; s < 4; s++) begin : g_bank
      cum_sel_bank u_bank (
         .clk    (clk),
         .rst_b  (rst_b),
         .we     (sel_we[s]),
         .ris_ok (ris_ok),
         .wdata  (req.wdata),
         .sel_q  (sel_q[s])
      );
   end

   // -----------------------------------------------------------------
   // Monitor steering
   // -----------------------------------------------------------------
   // The selector of the accessing space picks the entry. Without
   // resource selection the resource part is forced to zero.
   always_comb begin
      cur     = sel_q[req.space];
      ris_eff = ris_ok ? cur.resource_instance_select : 4'h0;
      oob     = (cur.mon >= `CUM_NUM_MON)
              | ({12'h000, ris_eff} >= `CUM_NUM_RIS);
      idx     = {req.space, ris_eff[1:0], cur.mon[2:0]};
   end

   // The read-only option blocks software writes to the counter.
   always_comb begin
      cnt_we = hit_cnt & req.write & !oob & !opt.usage_ro;
      cap_we = hit_cap & req.write & !oob;
   end

   // -----------------------------------------------------------------
   // Hardware updates
   // -----------------------------------------------------------------
   // Out-of-range updates are dropped rather than aliased.
   always_comb begin
      meas_ok  = meas.valid & cnt_present
               & (meas.mon < `CUM_NUM_MON)
               & ({12'h000, meas.resource_instance_select} < `CUM_NUM_RIS);
      meas_idx = {meas.space, meas.resource_instance_select[1:0], meas.mon[2:0]};
      cevt_ok  = cap_evt.valid & cap_present
               & (cap_evt.mon < `CUM_NUM_MON)
               & ({12'h000, cap_evt.resource_instance_select} < `CUM_NUM_RIS);
      cevt_idx = {cap_evt.space, cap_evt.resource_instance_select[1:0], cap_evt.mon[2:0]};
   end

   cum_mon_store u_store (
      .clk          (clk),
      .rst_b        (rst_b),
      .sw_cnt_we    (cnt_we),
      .sw_cap_we    (cap_we),
      .sw_idx       (idx),
      .sw_wdata     (req.wdata),
      .hw_meas_we   (meas_ok),
      .hw_meas_idx  (meas_idx),
      .hw_meas_word ({meas.not_ready_flag, meas.value}),
      .hw_cap_we    (cevt_ok),
      .hw_cap_idx   (cevt_idx),
      .rd_idx       (idx),
      .rd_cnt       (rd_cnt),
      .rd_cap       (rd_cap)
   );

   // -----------------------------------------------------------------
   // Read data and answer
   // -----------------------------------------------------------------
   // Reserved selector bits are rebuilt as zero on every read.
   always_comb begin
      sel_word = {4'h0, cur.resource_instance_select, 8'h00, cur.mon};
   end

   // Every request is answered one cycle later. Unmapped or absent
   // registers read zero with no error, which keeps probing cheap.
   always_comb begin
      rsp_d       = '0;
      rsp_d.ack   = req.valid;
      if (hit_sel && !req.write) begin
         rsp_d.rdata = sel_word;
      end else if (hit_cnt || hit_cap) begin
         if (oob) begin
            rsp_d.err = 1'b1;
         end else if (!req.write) begin
            rsp_d.rdata = hit_cnt ? rd_cnt : rd_cap;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   ack_follow_a : assert property (@(posedge clk) disable iff (!rst_b)
      req.valid |=> rsp_q.ack)
      else $error("request not answered next cycle");

   sel_back_a : assert property (@(posedge clk) disable iff (!rst_b)
      hit_sel && req.write
      |=> sel_q[$past(req.space)].mon == $past(req.wdata[15:0]))
      else $error("selector index not stored");

   ris_zero_a : assert property (@(posedge clk) disable iff (!rst_b)
      $past(hit_sel && !req.write && !ris_ok)
      |-> rsp_q.rdata[27:24] == 4'h0)
      else $error("resource field not zero when absent");

   resv_zero_a : assert property (@(posedge clk) disable iff (!rst_b)
      $past(hit_sel && !req.write)
      |-> rsp_q.rdata[31:28] == 4'h0 && rsp_q.rdata[23:16] == 8'h00)
      else $error("reserved selector bits not zero");

   realm_gate_a : assert property (@(posedge clk) disable iff (!rst_b)
      $past(req.valid && req.space[1] && !opt.realm_present)
      |-> rsp_q.rdata == 32'h00000000 && !rsp_q.err)
      else $error("gated frame not reserved");

   absent_zero_a : assert property (@(posedge clk) disable iff (!rst_b)
      $past(req.valid && req.addr == `CUM_CNT_OFF && !cnt_present)
      |-> rsp_q.rdata == 32'h00000000)
      else $error("absent counter not zero");

   oob_err_a : assert property (@(posedge clk) disable iff (!rst_b)
      $past((hit_cnt || hit_cap) && oob)
      |-> rsp_q.err && rsp_q.rdata == 32'h00000000)
      else $error("out of range access not flagged");

   meas_read_a : assert property (@(posedge clk) disable iff (!rst_b)
      meas_ok ##1 (!req.valid && !meas_ok) ##1 (hit_cnt && !req.write && !oob
                   && idx == $past(meas_idx, 2))
      |=> rsp_q.rdata == {$past(meas.not_ready_flag, 3), $past(meas.value, 3)})
      else $error("counter read does not show measurement");

   ro_hold_a : assert property (@(posedge clk) disable iff (!rst_b)
      (hit_cnt && req.write && opt.usage_ro && !meas_ok)
      ##1 (!req.valid && !meas_ok)
      ##1 (hit_cnt && !req.write && !oob && idx == $past(idx, 2))
      |=> rsp_q.rdata == $past(rd_cnt, 3))
      else $error("read-only counter changed by write");

   // -----------------------------------------------------------------
   // Answer and steering checks
   // -----------------------------------------------------------------
   // An answer never appears without a request one cycle before.
   ack_once_a : assert property (@(posedge clk) disable iff (!rst_b)
      rsp_q.ack |-> $past(req.valid))
      else $error("answer without request");

   // An idle bus leaves the whole answer at zero.
   idle_zero_a : assert property (@(posedge clk) disable iff (!rst_b)
      !req.valid |=> !rsp_q.ack && !rsp_q.err && rsp_q.rdata == 32'h00000000)
      else $error("answer while idle");

   // Writes return no data, whatever they hit.
   write_zero_a : assert property (@(posedge clk) disable iff (!rst_b)
      req.valid && req.write |=> rsp_q.rdata == 32'h00000000)
      else $error("write returned data");

   // The selector accepts any index, so it never reports an error.
   sel_noerr_a : assert property (@(posedge clk) disable iff (!rst_b)
      hit_sel |=> !rsp_q.err)
      else $error("selector access flagged");

   // Errors are kept to counter and capture accesses out of range.
   err_scope_a : assert property (@(posedge clk) disable iff (!rst_b)
      rsp_q.err |-> $past((hit_cnt || hit_cap) && oob))
      else $error("error without out of range access");

   // An out-of-range access must not alias onto a real entry.
   oob_drop_a : assert property (@(posedge clk) disable iff (!rst_b)
      (hit_cnt || hit_cap) && oob |-> !cnt_we && !cap_we)
      else $error("out of range write not dropped");

   // One selector write touches exactly the bank of its own space.
   sel_bank_a : assert property (@(posedge clk) disable iff (!rst_b)
      sel_we != 4'h0 |-> $onehot(sel_we) && sel_we[req.space])
      else $error("selector write hit another bank");

   // Gated frames must not change any state.
   gate_write_a : assert property (@(posedge clk) disable iff (!rst_b)
      req.valid && req.space[1] && !opt.realm_present
      |-> sel_we == 4'h0 && !cnt_we && !cap_we)
      else $error("gated frame changed state");

   // The resource field is stored only when selection exists.
   ris_keep_a : assert property (@(posedge clk) disable iff (!rst_b)
      hit_sel && req.write && ris_ok
      |=> sel_q[$past(req.space)].resource_instance_select == $past(req.wdata[27:24]))
      else $error("resource field not stored");

   ris_clear_a : assert property (@(posedge clk) disable iff (!rst_b)
      hit_sel && req.write && !ris_ok
      |=> sel_q[$past(req.space)].resource_instance_select == 4'h0)
      else $error("resource field stored when absent");

   // Without resource selection every access lands in resource zero.
   steer_noris_a : assert property (@(posedge clk) disable iff (!rst_b)
      hit_cnt && !ris_ok |-> idx[4:3] == 2'b00 && idx[6:5] == req.space)
      else $error("steering used a resource without selection");

   // The read-only option shuts out every software counter write.
   ro_gate_a : assert property (@(posedge clk) disable iff (!rst_b)
      opt.usage_ro |-> !cnt_we)
      else $error("counter written while read-only");

   // A software counter write reads back two cycles later.
   cnt_write_a : assert property (@(posedge clk) disable iff (!rst_b)
      (hit_cnt && req.write && !oob && !opt.usage_ro && !meas_ok)
      ##1 (!req.valid && !meas_ok)
      ##1 (hit_cnt && !req.write && idx == $past(idx, 2))
      |=> rsp_q.rdata == $past(req.wdata, 3))
      else $error("counter write not read back");

   // A software capture write reads back two cycles later.
   cap_write_a : assert property (@(posedge clk) disable iff (!rst_b)
      (hit_cap && req.write && !oob && !cevt_ok)
      ##1 (!req.valid && !cevt_ok)
      ##1 (hit_cap && !req.write && idx == $past(idx, 2))
      |=> rsp_q.rdata == $past(req.wdata, 3))
      else $error("capture write not read back");

   // An absent capture register reads zero with no error.
   absent_cap_a : assert property (@(posedge clk) disable iff (!rst_b)
      $past(req.valid && req.addr == `CUM_CAP_OFF && !cap_present)
      |-> rsp_q.rdata == 32'h00000000 && !rsp_q.err)
      else $error("absent capture not zero");

endmodule : cum_top

// *** verif/tb_cum_top.sv ***
`timescale 1ns/100ps
`include "cum_params.svh"

module tb_cum_top;
   import cum_pkg::*;

   // -----------------------------------------------------------------
   // Signals and counters
   // -----------------------------------------------------------------
   logic        clk;
   logic        rst_b;
   cum_req_t    req;
   cum_opt_t    opt;
   cum_meas_t   meas;
   cum_meas_t   cap_evt;
   cum_rsp_t    rsp_q;
   int          num_errors;
   int          num_checks;
   logic [31:0] rd;
   logic        er;
   // Straps with one presence option cleared each, and the counter word expected then.
   logic [6:0]  absent_straps [3] = '{7'h5D, 7'h6D, 7'h3D};
   logic [31:0] absent_cnt    [3] = '{32'h00000000, 32'h00000011, 32'h00000000};

   // One comparison; case equality so an unknown never matches.
   `define CHK(nm, exp, got) begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("wrong value %s expected %h seen %h", nm, exp, got); \
      end \
   end

   cum_top dut (
      .clk     (clk),
      .rst_b   (rst_b),
      .req     (req),
      .opt     (opt),
      .meas    (meas),
      .cap_evt (cap_evt),
      .rsp_q   (rsp_q)
   );

   // Free running 200 MHz clock.
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   // -----------------------------------------------------------------
   // Access tasks
   // -----------------------------------------------------------------
   // Straps are only changed under reset, since the design treats them as static.
   task automatic do_reset(input logic [6:0] straps);
      @(posedge clk);
      opt   <= straps;
      rst_b <= 1'h0;
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
   endtask : do_reset

   // One register access; the answer must come exactly one edge after it is taken.
   task automatic access(input logic w, input cum_space_t sp, input logic [11:0] a,
                         input logic [31:0] d, output logic [31:0] rdata, output logic err);
      @(posedge clk);
      req <= '{valid: 1'h1, write: w, space: sp, addr: a, wdata: d};
      @(posedge clk);
      req.valid <= 1'h0;
      #1;
      `CHK("ack", 1'h1, rsp_q.ack)
      rdata = rsp_q.rdata;
      err   = rsp_q.err;
   endtask : access

   task automatic wr(input cum_space_t sp, input logic [11:0] a, input logic [31:0] d);
      access(1'h1, sp, a, d, rd, er);
   endtask : wr

   task automatic rd_chk(input cum_space_t sp, input logic [11:0] a, input logic [31:0] exp,
                         input logic exp_err, input string nm);
      access(1'h0, sp, a, 32'h00000000, rd, er);
      `CHK(nm, exp, rd)
      `CHK("err", exp_err, er)
   endtask : rd_chk

   // Measurement update (c=0) or capture event (c=1) from the cache side.
   task automatic hw(input logic c, input cum_space_t sp, input logic [3:0] r,
                     input logic [15:0] m, input logic [31:0] w);
      @(posedge clk);
      if (c) begin
         cap_evt <= '{valid: 1'h1, space: sp, resource_instance_select: r, mon: m, not_ready_flag: w[31], value: w[30:0]};
      end else begin
         meas <= '{valid: 1'h1, space: sp, resource_instance_select: r, mon: m, not_ready_flag: w[31], value: w[30:0]};
      end
      @(posedge clk);
      meas.valid    <= 1'h0;
      cap_evt.valid <= 1'h0;
   endtask : hw

   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial begin
      num_errors = 0;
      num_checks = 0;
      rst_b      = 1'h0;
      req        = '0;
      meas       = '0;
      cap_evt    = '0;
      opt        = 7'h7D;
      do_reset(7'h7D);
      for (int i = 0; i < 4; i++) begin
         rd_chk(cum_space_t'(i), `CUM_SEL_OFF, 32'h00000000, 1'h0, "sel reset");
         rd_chk(cum_space_t'(i), `CUM_CNT_OFF, 32'h80000000, 1'h0, "cnt reset");
      end
      wr(CUM_SP_SEC, `CUM_SEL_OFF, 32'hFFFFFFFF);
      rd_chk(CUM_SP_SEC, `CUM_SEL_OFF, 32'h0F00FFFF, 1'h0, "sel fields");
      // Each space selects its own resource and monitor.
      for (int i = 0; i < 4; i++) begin
         wr(cum_space_t'(i), `CUM_SEL_OFF, 32'((i << 24) | (i + 1)));
         hw(1'h0, cum_space_t'(i), 4'(i), 16'(i + 1), 32'h00001000 + 32'(i));
      end
      for (int i = 0; i < 4; i++) begin
         rd_chk(cum_space_t'(i), `CUM_SEL_OFF, 32'((i << 24) | (i + 1)), 1'h0, "sel");
         rd_chk(cum_space_t'(i), `CUM_CNT_OFF, 32'h00001000 + 32'(i), 1'h0, "cnt");
      end
      hw(1'h0, CUM_SP_RL, 4'h3, 16'h0004, 32'hFFFFFFFF);
      rd_chk(CUM_SP_RL, `CUM_CNT_OFF, 32'hFFFFFFFF, 1'h0, "cnt not_ready_flag");
      // The secure bank pointed at the entry the nonsecure update wrote sees its own word.
      wr(CUM_SP_SEC, `CUM_SEL_OFF, 32'h01000002);
      rd_chk(CUM_SP_SEC, `CUM_CNT_OFF, 32'h80000000, 1'h0, "cnt sep");
      hw(1'h0, CUM_SP_SEC, 4'h1, 16'h0002, 32'h00000ABC);
      hw(1'h1, CUM_SP_SEC, 4'h1, 16'h0002, 32'h00000000);
      hw(1'h0, CUM_SP_SEC, 4'h1, 16'h0002, 32'h00000DEF);
      rd_chk(CUM_SP_SEC, `CUM_CAP_OFF, 32'h00000ABC, 1'h0, "cap");
      rd_chk(CUM_SP_SEC, `CUM_CNT_OFF, 32'h00000DEF, 1'h0, "cnt new");
      wr(CUM_SP_SEC, `CUM_CAP_OFF, 32'h12345678);
      rd_chk(CUM_SP_SEC, `CUM_CAP_OFF, 32'h12345678, 1'h0, "cap sw");
      wr(CUM_SP_SEC, `CUM_CNT_OFF, 32'h00000077);
      rd_chk(CUM_SP_SEC, `CUM_CNT_OFF, 32'h00000077, 1'h0, "cnt sw");
      rd_chk(CUM_SP_SEC, 12'h804, 32'h00000000, 1'h0, "unmapped");
      wr(CUM_SP_SEC, `CUM_SEL_OFF, 32'h00000008);
      rd_chk(CUM_SP_SEC, `CUM_CNT_OFF, 32'h00000000, 1'h1, "mon range");
      wr(CUM_SP_SEC, `CUM_SEL_OFF, 32'h04000000);
      rd_chk(CUM_SP_SEC, `CUM_CAP_OFF, 32'h00000000, 1'h1, "ris range");
      // Counter read-only for software, hardware updates still land.
      do_reset(7'h7F);
      wr(CUM_SP_NS, `CUM_CNT_OFF, 32'h00000055);
      rd_chk(CUM_SP_NS, `CUM_CNT_OFF, 32'h80000000, 1'h0, "cnt ro");
      hw(1'h0, CUM_SP_NS, 4'h0, 16'h0000, 32'h00000066);
      rd_chk(CUM_SP_NS, `CUM_CNT_OFF, 32'h00000066, 1'h0, "cnt ro hw");
      // Without the realm extension the root and realm banks are gated.
      do_reset(7'h7C);
      wr(CUM_SP_ROOT, `CUM_SEL_OFF, 32'h00000003);
      rd_chk(CUM_SP_ROOT, `CUM_SEL_OFF, 32'h00000000, 1'h0, "root gated");
      rd_chk(CUM_SP_RL, `CUM_CNT_OFF, 32'h00000000, 1'h0, "realm gated");
      wr(CUM_SP_SEC, `CUM_SEL_OFF, 32'h00000003);
      rd_chk(CUM_SP_SEC, `CUM_SEL_OFF, 32'h00000003, 1'h0, "sec open");
      // Resource field gone when either resource option is missing.
      for (int k = 0; k < 2; k++) begin
         do_reset(k ? 7'h75 : 7'h79);
         hw(1'h0, CUM_SP_SEC, 4'h0, 16'h0003, 32'h00000300);
         wr(CUM_SP_SEC, `CUM_SEL_OFF, 32'h02000003);
         rd_chk(CUM_SP_SEC, `CUM_SEL_OFF, 32'h00000003, 1'h0, "no ris sel");
         rd_chk(CUM_SP_SEC, `CUM_CNT_OFF, 32'h00000300, 1'h0, "no ris cnt");
      end
      // Missing monitoring, usage or capture support reads zero.
      for (int k = 0; k < 3; k++) begin
         do_reset(absent_straps[k]);
         hw(1'h0, CUM_SP_SEC, 4'h0, 16'h0000, 32'h00000011);
         rd_chk(CUM_SP_SEC, `CUM_CNT_OFF, absent_cnt[k], 1'h0, "absent cnt");
         rd_chk(CUM_SP_SEC, `CUM_CAP_OFF, 32'h00000000, 1'h0, "absent cap");
      end
      finish_test();
   end

   // Watchdog well beyond the few hundred cycles the sequence needs.
   initial begin
      #25000;
      num_errors++;
      finish_test();
   end

endmodule : tb_cum_top
